/* design/custom_insn_pkg.sv */
// Shared constants, field layout and carrier types for the custom instruction path
package custom_insn_pkg;

  localparam int XLEN = 32;
  localparam int REG_ADDR_W = 5;
  localparam int REG_COUNT = 32;

  // Major opcode reserved for custom instructions (binary 0001011)
  localparam logic [6:0] RESERVED_CUSTOM_OPCODE = 7'h0B;

  // Instruction word field positions and widths
  localparam int OPC_LSB = 0;
  localparam int OPC_W = 7;
  localparam int RD_LSB = 7;
  localparam int F3_LSB = 12;
  localparam int F3_W = 3;
  localparam int RS1_LSB = 15;
  localparam int RS2_LSB = 20;
  localparam int F7_LSB = 25;
  localparam int F7_W = 7;

  // funct7 and funct3 together select one of up to 1024 operations
  localparam int OP_SEL_W = F7_W + F3_W;
  localparam int OP_SPACE = 1024;

  // Iterations of the shift-add multiplier
  localparam int MUL_STEPS = 32;
  localparam int BYTE_W = 8;
  localparam int ROT_AMT_W = 5;

  // Register that reads as zero and ignores writes
  localparam logic [REG_ADDR_W-1:0] ZERO_REG = 5'h0;

  typedef enum logic [2:0] {
    OP_BYTE_SUM = 3'h0,
    OP_TO_GRAY = 3'h1,
    OP_BIT_REV = 3'h2,
    OP_ROTATE = 3'h3,
    OP_XOR = 3'h4,
    OP_MULTIPLY = 3'h5,
    OP_ADD_IMM = 3'h6,
    OP_POP_COUNT = 3'h7
  } cfu_op_e;

  // Register file write port
  typedef struct packed {
    logic valid;
    logic [REG_ADDR_W-1:0] addr;
    logic [XLEN-1:0] data;
  } wr_port_s;

  // Request from core to unit
  typedef struct packed {
    logic start;
    logic [F7_W-1:0] imm7_select;
    logic [F3_W-1:0] imm3_select;
    logic [XLEN-1:0] operand_a;
    logic [XLEN-1:0] operand_b;
  } unit_req_s;

  // Answer from unit to core
  typedef struct packed {
    logic done;
    logic [XLEN-1:0] result;
  } unit_rsp_s;

endpackage

/* design/custom_func_unit.sv */
// Custom function unit: single-cycle operations plus one multi-cycle multiply
`timescale 1ns/1ps
module custom_func_unit
  import custom_insn_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Core side
  input wire unit_req_s req_in,
  output unit_rsp_s rsp_out
);

  logic busy_r;
  logic [XLEN-1:0] acc_r;
  logic [XLEN-1:0] mcand_r;
  logic [XLEN-1:0] mplier_r;
  logic [$clog2(MUL_STEPS+1)-1:0] step_r;
  logic [XLEN-1:0] comb_result;
  logic [OP_SEL_W-1:0] op_sel;
  logic is_mul;
  logic mul_done;

  // Full operation index; only funct3 picks the function here, funct7 feeds parameters
  assign op_sel = {req_in.imm7_select, req_in.imm3_select};
  assign is_mul = (cfu_op_e'(op_sel[F3_W-1:0]) == OP_MULTIPLY);
  assign mul_done = busy_r && (step_r == ($clog2(MUL_STEPS+1))'(MUL_STEPS));

  always_comb begin
    comb_result = '0;
    case (cfu_op_e'(req_in.imm3_select))
      OP_BYTE_SUM: begin
        for (int i = 0; i < XLEN / BYTE_W; i++) begin
          comb_result = comb_result + XLEN'(req_in.operand_a[i*BYTE_W +: BYTE_W]);
        end
      end
      OP_TO_GRAY: comb_result = req_in.operand_a ^ (req_in.operand_a >> 1);
      OP_BIT_REV: begin
        for (int i = 0; i < XLEN; i++) begin
          comb_result[i] = req_in.operand_a[XLEN-1-i];
        end
      end
      OP_ROTATE: begin
        // Shift amount comes from the funct7 immediate
        comb_result = (req_in.operand_a << req_in.imm7_select[ROT_AMT_W-1:0]) |
                      (req_in.operand_a >> (XLEN'(XLEN) -
                       XLEN'(req_in.imm7_select[ROT_AMT_W-1:0])));
      end
      OP_XOR: comb_result = req_in.operand_a ^ req_in.operand_b;
      OP_ADD_IMM: begin
        comb_result = req_in.operand_a + req_in.operand_b + XLEN'(req_in.imm7_select);
      end
      OP_POP_COUNT: begin
        for (int i = 0; i < XLEN; i++) begin
          comb_result = comb_result + XLEN'(req_in.operand_a[i]);
        end
      end
      default: comb_result = '0;
    endcase
  end

  // Multiply answers MUL_STEPS+1 cycles after start and keeps its own state
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      step_r <= '0;
    end else if (req_in.start && is_mul) begin
      busy_r <= 1'b1;
      step_r <= '0;
    end else if (mul_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      step_r <= step_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_r <= '0;
      mcand_r <= '0;
      mplier_r <= '0;
    end else if (req_in.start && is_mul) begin
      acc_r <= '0;
      mcand_r <= req_in.operand_a;
      mplier_r <= req_in.operand_b;
    end else if (busy_r && !mul_done) begin
      if (mplier_r[0]) begin
        acc_r <= acc_r + mcand_r;
      end
      mcand_r <= mcand_r << 1;
      mplier_r <= mplier_r >> 1;
    end
  end

  // Single-cycle ops answer in the start cycle itself
  always_comb begin
    rsp_out.done = (req_in.start && !is_mul) || mul_done;
    rsp_out.result = mul_done ? acc_r : comb_result;
  end

endmodule

/* design/custom_insn_exec.sv */
// Core execute stage for custom-opcode instructions, register file and unit coupling
`timescale 1ns/1ps
module custom_insn_exec
  import custom_insn_pkg::*;
#(
  parameter bit CUSTOM_EN = 1'b1,
  parameter int STALL_CNT_W = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Instruction issue
  input wire logic insn_valid_in,
  input wire logic [XLEN-1:0] insn_word_in,
  output logic insn_ready_out,
  // Register file write from the rest of the pipeline
  input wire wr_port_s rf_wr_in,
  // Register file read for inspection
  input wire logic [REG_ADDR_W-1:0] rf_rd_addr_in,
  output logic [XLEN-1:0] rf_rd_data_out,
  // Interrupt request and acceptance
  input wire logic irq_req_in,
  output logic irq_pending_out,
  output logic irq_take_out,
  // Completion and exceptions
  output wr_port_s wb_out,
  output logic illegal_insn_out,
  output logic busy_out,
  output logic [STALL_CNT_W-1:0] stall_cycles_out
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } exec_state_e;

  exec_state_e state_r;
  exec_state_e state_nxt;

  logic [XLEN-1:0] regs_r [REG_COUNT];

  logic [OPC_W-1:0] dec_opcode;
  logic [REG_ADDR_W-1:0] dec_rd;
  logic [REG_ADDR_W-1:0] dec_rs1;
  logic [REG_ADDR_W-1:0] dec_rs2;
  logic [F3_W-1:0] dec_imm3;
  logic [F7_W-1:0] dec_imm7;
  logic is_custom;
  logic take_insn;
  logic take_irq;

  logic [XLEN-1:0] op_a_r;
  logic [XLEN-1:0] op_b_r;
  logic [F7_W-1:0] imm7_r;
  logic [F3_W-1:0] imm3_r;
  logic [REG_ADDR_W-1:0] rd_r;

  logic irq_pending_r;
  logic irq_take_r;
  logic illegal_r;
  wr_port_s wb_r;
  logic [STALL_CNT_W-1:0] stall_cnt_r;

  unit_req_s unit_req;
  unit_rsp_s unit_rsp;
  logic unit_finish;

  // Instruction field extraction
  assign dec_opcode = insn_word_in[OPC_LSB +: OPC_W];
  assign dec_rd = insn_word_in[RD_LSB +: REG_ADDR_W];
  assign dec_imm3 = insn_word_in[F3_LSB +: F3_W];
  assign dec_rs1 = insn_word_in[RS1_LSB +: REG_ADDR_W];
  assign dec_rs2 = insn_word_in[RS2_LSB +: REG_ADDR_W];
  assign dec_imm7 = insn_word_in[F7_LSB +: F7_W];

  // funct3/funct7 take no part in legality; they are the unit's business
  assign is_custom = (dec_opcode == RESERVED_CUSTOM_OPCODE);

  // A queued interrupt is served first whenever the stage is free
  assign take_irq = (state_r == ST_IDLE) && irq_pending_r;
  assign insn_ready_out = (state_r == ST_IDLE) && !irq_pending_r;
  assign take_insn = insn_valid_in && insn_ready_out;

  // Finish the instruction in the cycle the unit reports done
  assign unit_finish = (state_r != ST_IDLE) && unit_rsp.done;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_insn && is_custom && CUSTOM_EN) begin
          state_nxt = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_nxt = unit_rsp.done ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT: begin
        // No timeout: the stage waits as long as the unit needs
        if (unit_rsp.done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Register file in flip-flops; entry zero stays zero
  generate
    for (genvar g = 0; g < REG_COUNT; g++) begin : gen_reg
      if (g == 0) begin : gen_zero
        always_ff @(posedge clk_sys_in) begin
          regs_r[g] <= '0;
        end
      end else begin : gen_entry
        always_ff @(posedge clk_sys_in) begin
          if (rst_in) begin
            regs_r[g] <= '0;
          end else if (unit_finish && rd_r == REG_ADDR_W'(g)) begin
            // Custom writeback wins over a simultaneous pipeline write
            regs_r[g] <= unit_rsp.result;
          end else if (rf_wr_in.valid && rf_wr_in.addr == REG_ADDR_W'(g)) begin
            regs_r[g] <= rf_wr_in.data;
          end
        end
      end
    end
  endgenerate

  // Operands read straight from the register file at issue and then held
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      op_a_r <= '0;
      op_b_r <= '0;
      imm7_r <= '0;
      imm3_r <= '0;
      rd_r <= ZERO_REG;
    end else if (take_insn && is_custom && CUSTOM_EN) begin
      op_a_r <= regs_r[dec_rs1];
      op_b_r <= regs_r[dec_rs2];
      imm7_r <= dec_imm7;
      imm3_r <= dec_imm3;
      rd_r <= dec_rd;
    end
  end

  // Request fields come from the held registers, so they cannot move before done
  always_comb begin
    unit_req.start = (state_r == ST_ISSUE);
    unit_req.imm7_select = imm7_r;
    unit_req.imm3_select = imm3_r;
    unit_req.operand_a = op_a_r;
    unit_req.operand_b = op_b_r;
  end

  custom_func_unit u_unit (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .req_in(unit_req),
    .rsp_out(unit_rsp)
  );

  // Writeback report mirrors the register file write, updated on the same edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wb_r <= '0;
    end else begin
      wb_r.valid <= unit_finish;
      wb_r.addr <= unit_finish ? rd_r : wb_r.addr;
      wb_r.data <= unit_finish ? unit_rsp.result : wb_r.data;
    end
  end

  // Without the extension the opcode is simply not legal
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= take_insn && is_custom && !CUSTOM_EN;
    end
  end

  // Requests arriving during a stall are kept; set wins over the take
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_pending_r <= 1'b0;
    end else if (irq_req_in) begin
      irq_pending_r <= 1'b1;
    end else if (take_irq) begin
      irq_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_take_r <= 1'b0;
    end else begin
      irq_take_r <= take_irq;
    end
  end

  // Stall length of the current or last custom instruction, for profiling only
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      stall_cnt_r <= '0;
    end else if (take_insn && is_custom && CUSTOM_EN) begin
      stall_cnt_r <= '0;
    end else if (state_r != ST_IDLE) begin
      stall_cnt_r <= stall_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rf_rd_data_out <= '0;
    end else begin
      rf_rd_data_out <= regs_r[rf_rd_addr_in];
    end
  end

  assign wb_out = wb_r;
  assign illegal_insn_out = illegal_r;
  assign irq_pending_out = irq_pending_r;
  assign irq_take_out = irq_take_r;
  assign busy_out = (state_r != ST_IDLE);
  assign stall_cycles_out = stall_cnt_r;

endmodule

/* verification/insn_exec_properties.sv */
// Port-level assertions for the custom instruction execute stage
`timescale 1ns/1ps
module insn_exec_properties
  import custom_insn_pkg::*;
#(
  parameter bit CUSTOM_EN = 1'b1,
  parameter int STALL_CNT_W = 32
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Issue
  input wire logic insn_valid_in,
  input wire logic [XLEN-1:0] insn_word_in,
  input wire logic insn_ready_out,
  // Register file
  input wire wr_port_s rf_wr_in,
  input wire logic [REG_ADDR_W-1:0] rf_rd_addr_in,
  input wire logic [XLEN-1:0] rf_rd_data_out,
  // Interrupts
  input wire logic irq_req_in,
  input wire logic irq_pending_out,
  input wire logic irq_take_out,
  // Completion
  input wire wr_port_s wb_out,
  input wire logic illegal_insn_out,
  input wire logic busy_out,
  input wire logic [STALL_CNT_W-1:0] stall_cycles_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic take;
  logic custom;
  logic is_mul;
  assign take = insn_valid_in && insn_ready_out;
  assign custom = insn_word_in[OPC_LSB +: OPC_W] == RESERVED_CUSTOM_OPCODE;
  assign is_mul = insn_word_in[F3_LSB +: F3_W] == OP_MULTIPLY;

  a_busy_blocks_issue: assert property (busy_out |-> !insn_ready_out)
    else $error("ready high while busy");
  a_single_op_cycle: assert property (take && custom && CUSTOM_EN && !is_mul |=>
    busy_out ##1 !busy_out) else $error("single-cycle op stall length wrong");
  a_mul_op_length: assert property (take && custom && CUSTOM_EN && is_mul |->
    ##34 busy_out ##1 !busy_out) else $error("multiply stall length wrong");
  a_custom_never_illegal: assert property (CUSTOM_EN |-> !illegal_insn_out)
    else $error("illegal raised with unit present");
  a_absent_unit_illegal: assert property (take && custom && !CUSTOM_EN |=>
    illegal_insn_out) else $error("no illegal with unit absent");
  a_other_opcode_quiet: assert property (take && !custom |=>
    !busy_out && !illegal_insn_out) else $error("foreign opcode handled");
  a_irq_held_stall: assert property (busy_out |-> !irq_take_out)
    else $error("interrupt taken while stalled");
  a_irq_after_done: assert property (irq_pending_out && !busy_out |=> irq_take_out)
    else $error("queued interrupt not taken");
  a_wb_after_stall: assert property (wb_out.valid |-> $past(busy_out))
    else $error("writeback without preceding stall");
  a_wb_result_holds: assert property (!wb_out.valid |-> $stable(wb_out.data))
    else $error("result changed without writeback");

  c_mul_issue: cover property (take && custom && is_mul);
  c_irq_take: cover property (irq_take_out);
  c_illegal: cover property (illegal_insn_out);
endmodule

bind custom_insn_exec insn_exec_properties #(
  .CUSTOM_EN(CUSTOM_EN),
  .STALL_CNT_W(STALL_CNT_W)
) chk_u (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .insn_valid_in(insn_valid_in),
  .insn_word_in(insn_word_in), .insn_ready_out(insn_ready_out), .rf_wr_in(rf_wr_in),
  .rf_rd_addr_in(rf_rd_addr_in), .rf_rd_data_out(rf_rd_data_out), .irq_req_in(irq_req_in),
  .irq_pending_out(irq_pending_out), .irq_take_out(irq_take_out), .wb_out(wb_out),
  .illegal_insn_out(illegal_insn_out), .busy_out(busy_out),
  .stall_cycles_out(stall_cycles_out)
);

/* verification/insn_issue_model.sv */
// Pipeline front end model offering instruction words to the execute stage
`timescale 1ns/1ps
module insn_issue_model
  import custom_insn_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Issue handshake
  input wire logic ready_in,
  output logic valid_out,
  output logic [XLEN-1:0] word_out
);
  initial begin
    valid_out = 1'b0;
    word_out = '0;
  end

  // Word is held until taken, then inverted so stale fields are never reused
  task automatic issue(input logic [XLEN-1:0] word, input int delay, output bit taken);
    int n;
    n = 0;
    repeat (delay) @(posedge clk_sys_in);
    valid_out <= 1'b1;
    word_out <= word;
    @(posedge clk_sys_in);
    while (ready_in !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys_in);
    end
    taken = (ready_in === 1'b1);
    valid_out <= 1'b0;
    word_out <= ~word;
  endtask
endmodule

/* verification/test_custom_instruction_unit_port.sv */
// Self-checking bench for the custom instruction execute stage
`timescale 1ns/1ps
module test_custom_instruction_unit_port
  import custom_insn_pkg::*;
;
  logic clk_sys_in, rst_in, insn_valid_in, insn_ready_out, irq_req_in;
  logic irq_pending_out, irq_take_out, illegal_insn_out, busy_out, off_illegal;
  logic [XLEN-1:0] insn_word_in, rf_rd_data_out;
  logic [REG_ADDR_W-1:0] rf_rd_addr_in;
  logic [31:0] stall_cycles_out;
  wr_port_s rf_wr_in, wb_out;
  int fail_count = 0;
  int n_tests = 0;
  localparam logic [6:0] OPC = RESERVED_CUSTOM_OPCODE;

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  insn_issue_model model_u (.clk_sys_in(clk_sys_in), .ready_in(insn_ready_out),
    .valid_out(insn_valid_in), .word_out(insn_word_in));
  custom_insn_exec dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .insn_valid_in(insn_valid_in), .insn_word_in(insn_word_in), .insn_ready_out(insn_ready_out),
    .rf_wr_in(rf_wr_in), .rf_rd_addr_in(rf_rd_addr_in), .rf_rd_data_out(rf_rd_data_out),
    .irq_req_in(irq_req_in), .irq_pending_out(irq_pending_out), .irq_take_out(irq_take_out),
    .wb_out(wb_out), .illegal_insn_out(illegal_insn_out), .busy_out(busy_out),
    .stall_cycles_out(stall_cycles_out));
  // Unit left out: only its exception output matters here
  custom_insn_exec #(.CUSTOM_EN(1'b0)) dut_off_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .insn_valid_in(insn_valid_in), .insn_word_in(insn_word_in), .insn_ready_out(),
    .rf_wr_in(rf_wr_in), .rf_rd_addr_in(rf_rd_addr_in), .rf_rd_data_out(),
    .irq_req_in(irq_req_in), .irq_pending_out(), .irq_take_out(), .wb_out(),
    .illegal_insn_out(off_illegal), .busy_out(), .stall_cycles_out());

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [XLEN-1:0] word(input logic [6:0] f7, input logic [2:0] f3,
      input logic [4:0] ra, input logic [4:0] rb, input logic [4:0] rd, input logic [6:0] op);
    return {f7, rb, ra, f3, rd, op};
  endfunction

  function automatic logic [XLEN-1:0] exp_op(input logic [6:0] f7, input logic [2:0] f3,
      input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
    logic [XLEN-1:0] r;
    r = '0;
    case (f3)
      3'h0: r = a[7:0] + a[15:8] + a[23:16] + a[31:24];
      3'h1: r = a ^ (a >> 1);
      3'h2: for (int i = 0; i < 32; i++) r[i] = a[31-i];
      3'h3: r = (a << f7[4:0]) | (a >> (6'd32 - f7[4:0]));
      3'h4: r = a ^ b;
      3'h5: r = a * b;
      3'h6: r = a + b + f7;
      default: for (int i = 0; i < 32; i++) r = r + a[i];
    endcase
    return r;
  endfunction

  task automatic write_reg(input logic [4:0] a, input logic [XLEN-1:0] d);
    @(posedge clk_sys_in);
    rf_wr_in <= '{1'b1, a, d};
    @(posedge clk_sys_in);
    rf_wr_in <= '0;
  endtask

  task automatic check_reg(input logic [4:0] a, input logic [XLEN-1:0] exp);
    rf_rd_addr_in <= a;
    // Address lands on the first edge, data is registered on the second, seen after it
    repeat (3) @(posedge clk_sys_in);
    compare(rf_rd_data_out, exp);
  endtask

  // Issues one custom op and returns the edges until writeback
  task automatic issue_wait(input logic [XLEN-1:0] w, output int n);
    bit taken;
    model_u.issue(w, 0, taken);
    n = 0;
    if (!taken) begin
      fail_count++;
      print_verdict();
    end
    do begin
      @(posedge clk_sys_in);
      n++;
      if (n > 100) begin
        fail_count++;
        print_verdict();
      end
    end while (wb_out.valid !== 1'b1);
  endtask

  task automatic test_ops;
    int n;
    write_reg(5'h1, 32'h00ca_fe00);
    write_reg(5'h2, 32'h1234_5678);
    for (int f = 0; f < 8; f++) begin
      issue_wait(word(7'h27, 3'(f), 5'h1, 5'h2, 5'(f + 3), OPC), n);
      compare(n, (f == 5) ? 35 : 2);
      compare(wb_out.addr, 5'(f + 3));
      compare(stall_cycles_out, (f == 5) ? 34 : 1);
      compare(wb_out.data, exp_op(7'h27, 3'(f), 32'h00ca_fe00, 32'h1234_5678));
      check_reg(5'(f + 3), exp_op(7'h27, 3'(f), 32'h00ca_fe00, 32'h1234_5678));
    end
    $display("operation table done");
  endtask

  task automatic test_zero_reg;
    int n;
    write_reg(ZERO_REG, 32'hdead_beef);
    check_reg(ZERO_REG, 32'h0000_0000);
    issue_wait(word(7'h00, OP_XOR, ZERO_REG, 5'h2, 5'h1f, OPC), n);
    compare(wb_out.data, 32'h1234_5678);
    $display("zero register done");
  endtask

  task automatic test_other_opcodes;
    bit taken;
    int hits;
    hits = 0;
    for (int k = 0; k < 3; k++) begin
      model_u.issue(word(7'h00, 3'h4, 5'h1, 5'h2, 5'h4, (k == 0) ? 7'h33 : (k == 1) ? 7'h2b : 7'h0a),
        0, taken);
      repeat (3) begin
        @(posedge clk_sys_in);
        hits += (wb_out.valid !== 1'b0) + (busy_out !== 1'b0) + (off_illegal !== 1'b0);
      end
    end
    compare(hits, 0);
    $display("foreign opcodes done");
  endtask

  task automatic test_absent_unit;
    int n;
    bit taken;
    model_u.issue(word(7'h7f, 3'h7, 5'h1, 5'h2, 5'h9, OPC), 0, taken);
    @(posedge clk_sys_in);
    compare(off_illegal, 1'b1);
    compare(illegal_insn_out, 1'b0);
    @(posedge clk_sys_in);
    compare(wb_out.data, exp_op(7'h7f, 3'h7, 32'h00ca_fe00, 32'h1234_5678));
    $display("absent unit done");
  endtask

  task automatic test_irq_stall;
    int n;
    int early;
    bit taken;
    early = 0;
    model_u.issue(word(7'h00, OP_MULTIPLY, 5'h1, 5'h2, 5'h7, OPC), 0, taken);
    irq_req_in <= 1'b1;
    @(posedge clk_sys_in);
    irq_req_in <= 1'b0;
    repeat (33) begin
      @(posedge clk_sys_in);
      early += (irq_take_out !== 1'b0) + (irq_pending_out !== 1'b1);
    end
    @(posedge clk_sys_in);
    compare(wb_out.valid, 1'b1);
    compare(early, 0);
    @(posedge clk_sys_in);
    compare(irq_take_out, 1'b1);
    $display("interrupt during stall done");
  endtask

  initial begin
    rst_in = 1'b1;
    irq_req_in = 1'b0;
    rf_wr_in = '0;
    rf_rd_addr_in = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    compare({insn_ready_out, busy_out, wb_out.valid, irq_pending_out}, 4'h8);
    test_ops();
    test_zero_reg();
    test_other_opcodes();
    test_absent_unit();
    test_irq_stall();
    print_verdict();
  end
endmodule
